// *** bench/clock_sync_serial_channel_tb.sv ***
// Testbench driving the serial channel over APB and from the external partner.
`timescale 1ns/1ns
module clock_sync_serial_channel_tb
  import csio_pkg::*;
;
  logic        ref_clk, rstn, psel, penable, pwrite, errv, pready, pslverr;
  logic        clkIn, clkOut, clkOe, clkSec, sdo, sdi, rtsN;
  logic        prevSck = 1'b1;
  logic        ctsN = 1'b0;
  logic        sck;
  logic [7:0]  paddr;
  logic [7:0]  capSr = 8'h00;
  logic [31:0] pwdata, prdata, rdv;
  int          capCnt = 0;
  int          fail_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  clock_sync_serial_channel #(.CHANNEL(1)) i_clock_sync_serial_channel (
    .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .transfer_clock_pin_in(clkIn), .transfer_clock_pin_out(clkOut),
    .transfer_clock_pin_oe(clkOe), .secondary_clock_out_pin(clkSec),
    .serial_out_pin(sdo), .serial_in_pin(sdi), .clear_to_send_in(ctsN),
    .request_to_send_out(rtsN));
  csio_partner i_csio_partner (.ref_clk(ref_clk), .request_to_send_out(rtsN),
    .serial_out_pin(sdo), .extClk(clkIn), .serialIn(sdi));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      summarize();
    end
  end
  // Capture follows the pin that should carry the clock, so a wrong route loses bits.
  assign sck = clkOe ? clkOut : clkSec;
  always @(posedge ref_clk) begin
    prevSck <= sck;
    if (sck && !prevSck) begin
      capSr <= {sdo, capSr[7:1]};
      capCnt <= capCnt + 1;
    end
  end

  function automatic logic [31:0] fb(input int n);
    return 32'h1 << n;
  endfunction
  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev8[i] = v[7 - i];
  endfunction
  task automatic summarize();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic stat(input int idx, input logic exp);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk($sformatf("status bit %0d", idx), {31'h0, exp}, {31'h0, rdv[idx]});
  endtask

  task automatic regCase();
    apb(1'b0, CTRL_OFFSET, 32'h0);
    chk("ctrl reset", {16'h0, CTRL_RESET}, rdv);
    apb(1'b1, CTRL_OFFSET, 32'h000001f0);
    apb(1'b1, 8'h14, 32'h0000ffff);
    chk("unmapped write error", 32'h1, {31'h0, errv});
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped read error", 32'h1, {31'h0, errv});
    chk("unmapped read data", 32'h0, rdv);
    apb(1'b0, CTRL_OFFSET, 32'h0);
    chk("ctrl readback", 32'h000001f0, rdv);
  endtask
  task automatic txCase(input logic [31:0] ctl, input logic [1:0] pre, input logic [7:0] d);
    int cap0;
    apb(1'b1, CTRL_OFFSET, ctl);
    apb(1'b1, PRESC_OFFSET, {30'h0, pre});
    cap0 = capCnt;
    ctsN <= ctl[CTRL_CTSEN];
    apb(1'b1, TXBUF_OFFSET, {24'h0, d});
    if (ctl[CTRL_CTSEN]) begin
      // With clear-to-send held high the byte must wait in the buffer.
      repeat (40) @(posedge ref_clk);
      stat(STAT_TXREMPTY, 1'b1);
      chk("clock while cts high", 32'(cap0), 32'(capCnt));
      ctsN <= 1'b0;
    end
    if (pre != PRESC_F1) begin
      while (capCnt < cap0 + 2) @(posedge ref_clk);
      stat(STAT_TXIRQ, !ctl[CTRL_TXISRC]);
      stat(STAT_TXREMPTY, 1'b0);
    end
    while (capCnt < cap0 + 8) @(posedge ref_clk);
    repeat (3) @(posedge ref_clk);
    chk("tx byte", {24'h0, (ctl[CTRL_MSBF] ? rev8(d) : d)}, {24'h0, capSr});
    stat(STAT_TXREMPTY, 1'b1);
    stat(STAT_TXIRQ, 1'b1);
    apb(1'b1, STATUS_OFFSET, 32'h30);
  endtask
  task automatic rxCase();
    logic [31:0] ctl;
    ctl = fb(CTRL_RXEN) | fb(CTRL_EXTCLK) | fb(CTRL_RTSEN);
    apb(1'b1, CTRL_OFFSET, ctl);
    repeat (3) @(posedge ref_clk);
    chk("rts on receive enable", 32'h0, {31'h0, rtsN});
    apb(1'b1, CTRL_OFFSET, ctl | fb(CTRL_TXEN));
    apb(1'b1, TXBUF_OFFSET, 32'h0000003c);
    i_csio_partner.send(8'h96);
    chk("dummy out", 32'h3c, {24'h0, i_csio_partner.heard});
    chk("rts after reception", 32'h0, {31'h0, rtsN});
    stat(STAT_RXDONE, 1'b1);
    stat(STAT_RXIRQ, 1'b1);
    apb(1'b0, RXBUF_OFFSET, 32'h0);
    chk("rx byte", 32'h96, rdv);
    stat(STAT_RXDONE, 1'b0);
    apb(1'b1, TXBUF_OFFSET, 32'h0);
    i_csio_partner.send(8'h11);
    apb(1'b1, STATUS_OFFSET, 32'h30);
    apb(1'b1, TXBUF_OFFSET, 32'h0);
    i_csio_partner.send(8'h5a);
    stat(STAT_OVERRUN, 1'b1);
    stat(STAT_RXIRQ, 1'b0);
    apb(1'b0, RXBUF_OFFSET, 32'h0);
    chk("overrun byte", 32'h5a, rdv);
    chk("rts seen", 32'h0, {31'h0, i_csio_partner.rtsMissed});
  endtask

  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    regCase();
    txCase(fb(CTRL_TXEN) | fb(CTRL_TXISRC), PRESC_F1, 8'ha5);
    txCase(fb(CTRL_TXEN) | fb(CTRL_MSBF) | fb(CTRL_CTSEN), PRESC_F8, 8'h3c);
    txCase(fb(CTRL_TXEN) | fb(CTRL_TXISRC) | fb(CTRL_CKSEL0) | fb(CTRL_CKSEL1),
      PRESC_F32, 8'h81);
    rxCase();
    summarize();
  end
endmodule // clock_sync_serial_channel_tb

// *** bench/csio_monitor.sv ***
// Port checker of the serial channel, bound to its top module.
`timescale 1ns/1ns
module csio_monitor
  import csio_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rstn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins
  input wire logic        transfer_clock_pin_out,
  input wire logic        transfer_clock_pin_oe,
  input wire logic        secondary_clock_out_pin,
  input wire logic        request_to_send_out
);
  logic [15:0] shCtrl_reg, shCtrl_next;
  logic [1:0]  shPresc_reg, shPresc_next;
  logic [2:0]  upCnt_reg, upCnt_next;
  logic        wrDone, ext, routed, steady;
  assign wrDone = psel && penable && pready && pwrite;
  assign ext = shCtrl_reg[CTRL_EXTCLK];
  assign routed = shCtrl_reg[CTRL_CKSEL0] && shCtrl_reg[CTRL_CKSEL1];
  // Outputs lag the released reset by the two-flop synchroniser, so pin checks wait a while.
  assign steady = upCnt_reg == 3'h7;
  always_comb begin
    shCtrl_next = shCtrl_reg;
    shPresc_next = shPresc_reg;
    upCnt_next = steady ? upCnt_reg : upCnt_reg + 3'h1;
    if (wrDone && paddr == CTRL_OFFSET) begin
      shCtrl_next = pwdata[15:0];
    end
    if (wrDone && paddr == PRESC_OFFSET) begin
      shPresc_next = pwdata[1:0];
    end
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      shCtrl_reg <= CTRL_RESET;
      shPresc_reg <= PRESC_F1;
      upCnt_reg <= 3'h0;
    end else begin
      shCtrl_reg <= shCtrl_next;
      shPresc_reg <= shPresc_next;
      upCnt_reg <= upCnt_next;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  AST_PREADY_NEXT: assert property (psel && !penable |=> pready)
    else $error("pready did not follow the setup cycle");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  AST_UNMAPPED: assert property (psel && !penable && paddr > PRESC_OFFSET
    |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_MAPPED: assert property (psel && !penable && paddr[1:0] == 2'h0 && paddr <= PRESC_OFFSET
    |=> !pslverr)
    else $error("mapped access refused");
  AST_RTS_INTERNAL: assert property (steady && !ext && $stable(shCtrl_reg) |-> request_to_send_out)
    else $error("request to send active with internal clock");
  AST_OE_ROUTE: assert property (steady && !ext && $stable(shCtrl_reg)
    |-> transfer_clock_pin_oe == !routed)
    else $error("clock pin enable does not follow routing");
  AST_SEC_IDLE: assert property (steady && !routed && $stable(shCtrl_reg) |-> secondary_clock_out_pin)
    else $error("secondary clock pin not idle high");
  AST_F1_RATE: assert property (transfer_clock_pin_oe && shPresc_reg == PRESC_F1
    && !shCtrl_reg[CTRL_CKPOL] && $fell(transfer_clock_pin_out) |=> transfer_clock_pin_out)
    else $error("undivided clock low longer than one cycle");
  AST_F8_RATE: assert property (transfer_clock_pin_oe && shPresc_reg == PRESC_F8
    && !shCtrl_reg[CTRL_CKPOL] && $fell(transfer_clock_pin_out) |=> !transfer_clock_pin_out [*3])
    else $error("divided clock low phase too short");
  cover property (transfer_clock_pin_oe && $fell(transfer_clock_pin_out));
  cover property (steady && !request_to_send_out);
  cover property (pready && pslverr);
  cover property (!secondary_clock_out_pin);
endmodule // csio_monitor

bind clock_sync_serial_channel csio_monitor i_csio_monitor (
  .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .transfer_clock_pin_out(transfer_clock_pin_out),
  .transfer_clock_pin_oe(transfer_clock_pin_oe),
  .secondary_clock_out_pin(secondary_clock_out_pin),
  .request_to_send_out(request_to_send_out));

// *** bench/csio_partner.sv ***
// Model of the external serial IC that clocks bytes into the channel.
`timescale 1ns/1ns
module csio_partner (
  // Clock
  input  wire logic ref_clk,
  // Device side
  input  wire logic request_to_send_out,
  input  wire logic serial_out_pin,
  output logic      extClk,
  output logic      serialIn
);
  logic [7:0] heard = 8'h00;
  logic       rtsMissed = 1'b0;
  initial begin
    extClk = 1'b1;
    serialIn = 1'b1;
  end
  // Half periods of four cycles leave room for the pin edge detector inside the channel.
  task automatic send(input logic [7:0] d);
    int n;
    n = 0;
    while (request_to_send_out !== 1'b0 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    rtsMissed = rtsMissed | (n >= 200);
    for (int i = 0; i < 8; i++) begin
      extClk <= 1'b0;
      serialIn <= d[i];
      repeat (4) @(posedge ref_clk);
      extClk <= 1'b1;
      heard[i] = serial_out_pin;
      repeat (4) @(posedge ref_clk);
    end
    // A released line has no pull, so it shows the inverse rather than the last bit.
    serialIn <= ~d[7];
    repeat (8) @(posedge ref_clk);
  endtask
endmodule // csio_partner

// *** src/clock_sync_serial_channel.sv ***
// Clock-synchronous serial channel with APB register access.
// Overview of operation
// - Setting transmit enable makes the channel ready to transmit.
// - Buffer moves to shifter at once on internal clock, on first shift edge on external; bits leave LSB first unless MSB first is selected.
// - After a byte: shift register empty flag, clock high for polarity 0 and low for 1, optional tx interrupt.
// - On channel 1 with internal clock, both clock-pin select bits set route the clock to the secondary pin.
// - Separate-pin handshake exists only on channel 0 and kills channel 1 clear-to-send.
// - Polarity 0 drives on falling, samples on rising; polarity 1 swaps.
// - Channel 2 alone has data inversion and pin-level inversion; 0 means none.
// - Internal clock derived from system clock divided by 2, 8 or 32.
// - Dummy write with both enables arms reception; request-to-send is already low from receive enable.
// - With LSB first, each sample edge puts input in top bit and shifts right; MSB first shifts left into bit 0.
// - Full byte goes to receive buffer, clock stops at the inverse of the polarity bit, done and irq set.
// - Reading the receive buffer clears the receive done flag.
// - Request-to-send has no handshake role with the internal clock.
// - Reception needs the transmitter; dummy data goes out while receiving.
// - Internal clock runs once enabled and loaded; external also needs pin toggles.
// - Byte arriving with done still set: overrun, overwrite, no receive irq.
// - Request-to-send low on receive enable, high during reception, low after.
// - Bit order option selects LSB first or MSB first.
// - Continuous receive mode rearms reception when the receive buffer is read.
// - Transmit interrupt on buffer-to-shifter move or on shift completion.
`timescale 1ns/1ns
module clock_sync_serial_channel
  import csio_pkg::*;
#(
  parameter int CHANNEL = 1
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial pins
  input  wire logic        transfer_clock_pin_in,
  output logic             transfer_clock_pin_out,
  output logic             transfer_clock_pin_oe,
  output logic             secondary_clock_out_pin,
  output logic             serial_out_pin,
  input  wire logic        serial_in_pin,
  input  wire logic        clear_to_send_in,
  output logic             request_to_send_out
);

  if (CHANNEL < 0 || CHANNEL > 2) begin : g_bad_channel
    $error("CHANNEL must be 0, 1 or 2");
  end

  localparam bit HAS_CKS1 = (CHANNEL == 1);
  localparam bit HAS_INV  = (CHANNEL == 2);
  localparam bit HAS_SEP  = (CHANNEL == 0);

  typedef enum {ST_IDLE, ST_SHIFT} state_t;

  logic        rstPipe_reg;
  logic        rstSync;
  logic [15:0] ctrl_reg,    ctrl_next;
  logic [1:0]  presc_reg,   presc_next;
  logic [7:0]  txBuf_reg,   txBuf_next;
  logic        txFull_reg,  txFull_next;
  logic [7:0]  txSh_reg,    txSh_next;
  logic [7:0]  rxSh_reg,    rxSh_next;
  logic [7:0]  rxBuf_reg,   rxBuf_next;
  logic [3:0]  bitCnt_reg,  bitCnt_next;
  logic        rxDone_reg,  rxDone_next;
  logic        ovr_reg,     ovr_next;
  logic        txIrq_reg,   txIrq_next;
  logic        rxIrq_reg,   rxIrq_next;
  logic        rxArmed_reg, rxArmed_next;
  logic        rxActive_reg, rxActive_next;
  logic        txOut_reg,   txOut_next;
  logic        rts_reg,     rts_next;
  logic        ckOut_reg,   ckOut_next;
  logic        ckOe_reg,    ckOe_next;
  logic        cks1_reg,    cks1_next;
  logic [31:0] prdata_reg,  prdata_next;
  logic        pready_reg,  pready_next;
  logic        pslverr_reg, pslverr_next;
  state_t      state_reg,   state_next;

  logic wrAcc;
  logic txWr;
  logic rdAcc;
  logic txEn, rxEn, extClk, msbFirst, ctsUse, rtsUse, cksSel, dInv, txInv, rxInv;
  logic rxBit;
  logic [7:0] loadByte;

  shift_if sif ();

  sclk_gen u_sclk (
    .ref_clk     (ref_clk),
    .rstSync     (rstSync),
    .extClk      (extClk),
    .clkPol      (ctrl_reg[CTRL_CKPOL]),
    .prescSel    (presc_reg),
    .extPinLevel (transfer_clock_pin_in),
    .sif         (sif)
  );

  // Two-stage reset release keeps the deassertion synchronous to ref_clk.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rstPipe_reg <= 1'b0;
      rstSync     <= 1'b0;
    end else begin
      rstPipe_reg <= 1'b1;
      rstSync     <= rstPipe_reg;
    end
  end

  assign txEn     = ctrl_reg[CTRL_TXEN];
  assign rxEn     = ctrl_reg[CTRL_RXEN];
  assign extClk   = ctrl_reg[CTRL_EXTCLK];
  assign msbFirst = ctrl_reg[CTRL_MSBF];
  // Clear-to-send on channel 1 disappears when channel 0 separates its pins or CKS1 is used; request-to-send is kept.
  assign ctsUse   = ctrl_reg[CTRL_CTSEN] && !ctrl_reg[CTRL_HSDIS] && !cksSel;
  assign rtsUse   = ctrl_reg[CTRL_RTSEN] && extClk;
  assign cksSel   = HAS_CKS1 && ctrl_reg[CTRL_CKSEL0] && ctrl_reg[CTRL_CKSEL1]
                    && !extClk;
  assign dInv     = HAS_INV && ctrl_reg[CTRL_DINV];
  assign txInv    = HAS_INV && ctrl_reg[CTRL_TXINV];
  assign rxInv    = HAS_INV && ctrl_reg[CTRL_RXINV];
  // Data inversion is applied once, when the receive buffer is read.
  assign rxBit    = serial_in_pin ^ rxInv;
  assign wrAcc    = psel && penable && pwrite && pready_reg;
  assign rdAcc    = psel && penable && !pwrite && pready_reg;
  assign txWr     = wrAcc && paddr == TXBUF_OFFSET;
  assign loadByte = txBuf_reg;
  assign sif.run  = (state_reg == ST_SHIFT);

  always_comb begin
    ctrl_next     = ctrl_reg;
    presc_next    = presc_reg;
    txBuf_next    = txBuf_reg;
    txFull_next   = txFull_reg;
    txSh_next     = txSh_reg;
    rxSh_next     = rxSh_reg;
    rxBuf_next    = rxBuf_reg;
    bitCnt_next   = bitCnt_reg;
    rxDone_next   = rxDone_reg;
    ovr_next      = ovr_reg;
    txIrq_next    = txIrq_reg;
    rxIrq_next    = rxIrq_reg;
    rxArmed_next  = rxArmed_reg;
    rxActive_next = rxActive_reg;
    txOut_next    = txOut_reg;
    state_next    = state_reg;
    prdata_next   = 32'h0000_0000;
    pready_next   = psel && !pready_reg;
    pslverr_next  = 1'b0;

    // Register access; pready answers one cycle after setup.
    if (psel && !pready_reg) begin
      case (paddr)
        CTRL_OFFSET:   prdata_next = {16'h0000, ctrl_reg};
        STATUS_OFFSET: prdata_next = {26'h0, rxIrq_reg, txIrq_reg, ovr_reg, rxDone_reg,
                                      (state_reg == ST_IDLE), !txFull_reg};
        TXBUF_OFFSET:  prdata_next = {24'h0, txBuf_reg};
        RXBUF_OFFSET:  prdata_next = {24'h0, rxBuf_reg ^ {8{dInv}}};
        PRESC_OFFSET:  prdata_next = {30'h0, presc_reg};
        default:       pslverr_next = 1'b1;
      endcase
      if (pwrite) prdata_next = 32'h0000_0000;
    end
    if (wrAcc) begin
      case (paddr)
        CTRL_OFFSET: begin
          ctrl_next = pwdata[CTRL_WIDTH-1:0];
          if (!HAS_SEP) ctrl_next[CTRL_SEPHS] = 1'b0;
          if (!pwdata[CTRL_RXEN]) begin
            ovr_next     = 1'b0;
            rxArmed_next = 1'b0;
          end
        end
        STATUS_OFFSET: begin
          if (pwdata[STAT_TXIRQ]) txIrq_next = 1'b0;
          if (pwdata[STAT_RXIRQ]) rxIrq_next = 1'b0;
        end
        TXBUF_OFFSET: begin
          txBuf_next  = pwdata[7:0] ^ {8{dInv}};
          txFull_next = 1'b1;
          if (rxEn) rxArmed_next = 1'b1;
        end
        PRESC_OFFSET: presc_next = pwdata[1:0];
        default: ;
      endcase
    end
    if (rdAcc && paddr == RXBUF_OFFSET) begin
      rxDone_next = 1'b0;
      if (ctrl_reg[CTRL_CONTRX] && rxEn) rxArmed_next = 1'b1;
    end

    case (state_reg)
      ST_IDLE: begin
        // Start with data loaded and CTS low if used; the external clock also waits for its first drive edge.
        if (txEn && txFull_reg && (!ctsUse || !clear_to_send_in)) begin
          if (extClk ? sif.shiftEdge : 1'b1) begin
            txSh_next   = msbFirst ? {loadByte[6:0], 1'b0} : {1'b0, loadByte[7:1]};
            txOut_next  = (msbFirst ? loadByte[7] : loadByte[0]) ^ txInv;
            // A buffer write in the same cycle keeps the buffer full; the old byte is taken.
            txFull_next = txWr;
            bitCnt_next = 4'h0;
            state_next  = ST_SHIFT;
            rxActive_next = rxEn && rxArmed_reg;
            if (rxEn && rxArmed_reg && !txWr) rxArmed_next = 1'b0;
            if (!ctrl_reg[CTRL_TXISRC]) txIrq_next = 1'b1;
          end
        end
      end
      ST_SHIFT: begin
        if (sif.sampleEdge) begin
          rxSh_next   = msbFirst ? {rxSh_reg[6:0], rxBit} : {rxBit, rxSh_reg[7:1]};
          bitCnt_next = bitCnt_reg + 4'h1;
          if (bitCnt_reg == 4'(BITS_PER_BYTE - 1)) begin
            state_next = ST_IDLE;
            if (ctrl_reg[CTRL_TXISRC]) txIrq_next = 1'b1;
            if (rxActive_reg) begin
              rxBuf_next = msbFirst ? {rxSh_reg[6:0], rxBit} : {rxBit, rxSh_reg[7:1]};
              rxActive_next = 1'b0;
              if (rxDone_reg && !(rdAcc && paddr == RXBUF_OFFSET)) begin
                ovr_next = 1'b1;
              end else begin
                rxDone_next = 1'b1;
                rxIrq_next  = 1'b1;
              end
            end
          end
        end else if (sif.shiftEdge && bitCnt_reg != 4'h0) begin
          txOut_next = (msbFirst ? txSh_reg[7] : txSh_reg[0]) ^ txInv;
          txSh_next  = msbFirst ? {txSh_reg[6:0], 1'b0} : {1'b0, txSh_reg[7:1]};
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // Pin outputs; the clock idles at the inverse of the polarity bit whenever no byte is moving.
  always_comb begin
    ckOut_next = sif.clkLevel ^ ctrl_reg[CTRL_CKPOL];
    if (state_next == ST_IDLE) ckOut_next = !ctrl_reg[CTRL_CKPOL];
    ckOe_next  = !extClk && !cksSel;
    cks1_next  = cksSel ? ckOut_next : 1'b1;
    // RTS low while receive is enabled and idle, high during a reception.
    rts_next   = rtsUse ? !(rxEn && !rxActive_next) : 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) begin
      ctrl_reg     <= CTRL_RESET;
      presc_reg    <= PRESC_F1;
      txBuf_reg    <= 8'h00;
      txFull_reg   <= 1'b0;
      txSh_reg     <= 8'h00;
      rxSh_reg     <= 8'h00;
      rxBuf_reg    <= 8'h00;
      bitCnt_reg   <= 4'h0;
      rxDone_reg   <= 1'b0;
      ovr_reg      <= 1'b0;
      txIrq_reg    <= 1'b0;
      rxIrq_reg    <= 1'b0;
      rxArmed_reg  <= 1'b0;
      rxActive_reg <= 1'b0;
      txOut_reg    <= 1'b1;
      rts_reg      <= 1'b1;
      ckOut_reg    <= 1'b1;
      ckOe_reg     <= 1'b0;
      cks1_reg     <= 1'b1;
      prdata_reg   <= 32'h0000_0000;
      pready_reg   <= 1'b0;
      pslverr_reg  <= 1'b0;
      state_reg    <= ST_IDLE;
    end else begin
      ctrl_reg     <= ctrl_next;
      presc_reg    <= presc_next;
      txBuf_reg    <= txBuf_next;
      txFull_reg   <= txFull_next;
      txSh_reg     <= txSh_next;
      rxSh_reg     <= rxSh_next;
      rxBuf_reg    <= rxBuf_next;
      bitCnt_reg   <= bitCnt_next;
      rxDone_reg   <= rxDone_next;
      ovr_reg      <= ovr_next;
      txIrq_reg    <= txIrq_next;
      rxIrq_reg    <= rxIrq_next;
      rxArmed_reg  <= rxArmed_next;
      rxActive_reg <= rxActive_next;
      txOut_reg    <= txOut_next;
      rts_reg      <= rts_next;
      ckOut_reg    <= ckOut_next;
      ckOe_reg     <= ckOe_next;
      cks1_reg     <= cks1_next;
      prdata_reg   <= prdata_next;
      pready_reg   <= pready_next;
      pslverr_reg  <= pslverr_next;
      state_reg    <= state_next;
    end
  end

  assign prdata                  = prdata_reg;
  assign pready                  = pready_reg;
  assign pslverr                 = pslverr_reg;
  assign transfer_clock_pin_out  = ckOut_reg;
  assign transfer_clock_pin_oe   = ckOe_reg;
  assign secondary_clock_out_pin = cks1_reg;
  assign serial_out_pin          = txOut_reg;
  assign request_to_send_out     = rts_reg;

endmodule // clock_sync_serial_channel

// *** src/csio_pkg.sv ***
// Package with register map, field positions and timing constants of the serial channel.
package csio_pkg;

  // Register byte addresses on the APB slave.
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] TXBUF_OFFSET  = 8'h08;
  localparam logic [7:0] RXBUF_OFFSET  = 8'h0c;
  localparam logic [7:0] PRESC_OFFSET  = 8'h10;

  // Control register field positions.
  localparam int CTRL_TXEN    = 0;
  localparam int CTRL_RXEN    = 1;
  localparam int CTRL_EXTCLK  = 2;
  localparam int CTRL_CKPOL   = 3;
  localparam int CTRL_MSBF    = 4;
  localparam int CTRL_CONTRX  = 5;
  localparam int CTRL_TXISRC  = 6;
  localparam int CTRL_CTSEN   = 7;
  localparam int CTRL_RTSEN   = 8;
  localparam int CTRL_CKSEL0  = 9;
  localparam int CTRL_CKSEL1  = 10;
  localparam int CTRL_DINV    = 11;
  localparam int CTRL_TXINV   = 12;
  localparam int CTRL_RXINV   = 13;
  localparam int CTRL_SEPHS   = 14;
  localparam int CTRL_HSDIS   = 15;
  localparam int CTRL_WIDTH   = 16;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // Status register field positions.
  localparam int STAT_TXBEMPTY = 0;
  localparam int STAT_TXREMPTY = 1;
  localparam int STAT_RXDONE   = 2;
  localparam int STAT_OVERRUN  = 3;
  localparam int STAT_TXIRQ    = 4;
  localparam int STAT_RXIRQ    = 5;
  localparam int STAT_WIDTH    = 6;

  // Prescaler choices: divide by 2, 8 or 32.
  localparam logic [1:0] PRESC_F1  = 2'h0;
  localparam logic [1:0] PRESC_F8  = 2'h1;
  localparam logic [1:0] PRESC_F32 = 2'h2;
  localparam int DIV_F8  = 8;
  localparam int DIV_F32 = 32;

  localparam int BITS_PER_BYTE = 8;

endpackage

// *** src/sclk_gen.sv ***
// Transfer clock source: internal prescaled clock or external clock pin edge detector.
`timescale 1ns/1ns
module sclk_gen
  import csio_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rstSync,
  // Configuration
  input  wire logic extClk,
  input  wire logic clkPol,
  input  wire logic [1:0] prescSel,
  input  wire logic extPinLevel,
  // Edge events
  shift_if.gen      sif
);

  logic [5:0] divCnt_reg;
  logic [5:0] divCnt_next;
  logic       intLvl_reg;
  logic       intLvl_next;
  logic       extPrev_reg;
  logic       extPrev_next;
  logic       extLvl;
  logic [5:0] halfDiv;
  logic       fall;
  logic       rise;

  // The external pin is seen in the polarity-0 sense, like the internal level.
  assign extLvl = extPinLevel ^ clkPol;

  // Half-period count; f1 toggles each cycle so a full period is two ref_clk cycles.
  always_comb begin
    case (prescSel)
      PRESC_F8:  halfDiv = 6'(DIV_F8 / 2 - 1);
      PRESC_F32: halfDiv = 6'(DIV_F32 / 2 - 1);
      default:   halfDiv = 6'h00;
    endcase
  end

  always_comb begin
    divCnt_next  = divCnt_reg;
    intLvl_next  = 1'b1;
    extPrev_next = extLvl;
    fall = 1'b0;
    rise = 1'b0;
    if (extClk) begin
      // Edges pass in idle too, since the first drive edge is what starts a byte.
      fall = extPrev_reg && !extLvl;
      rise = !extPrev_reg && extLvl;
      divCnt_next = 6'h00;
    end else if (sif.run) begin
      intLvl_next = intLvl_reg;
      if (divCnt_reg == halfDiv) begin
        divCnt_next = 6'h00;
        intLvl_next = !intLvl_reg;
        fall = intLvl_reg;
        rise = !intLvl_reg;
      end else begin
        divCnt_next = divCnt_reg + 6'h01;
      end
    end else begin
      divCnt_next = 6'h00;
    end
  end

  always_ff @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) begin
      divCnt_reg  <= 6'h00;
      intLvl_reg  <= 1'b1;
      extPrev_reg <= 1'b1;
    end else begin
      divCnt_reg  <= divCnt_next;
      intLvl_reg  <= intLvl_next;
      extPrev_reg <= extPrev_next;
    end
  end

  // Both sources idle high in this sense, so the drive edge is always the falling one.
  assign sif.shiftEdge  = fall;
  assign sif.sampleEdge = rise;
  // The next level is handed over so the registered pin lines up with the shift events.
  assign sif.clkLevel   = intLvl_next;

endmodule // sclk_gen

// *** src/shift_if.sv ***
// Interface carrying transfer-clock edge events from the clock generator to the shifter.
`timescale 1ns/1ns
interface shift_if;
  logic run;
  logic shiftEdge;
  logic sampleEdge;
  logic clkLevel;

  modport gen (input run, output shiftEdge, output sampleEdge, output clkLevel);
  modport use_side (output run, input shiftEdge, input sampleEdge, input clkLevel);
endinterface
